// file: design/gsm_pkg.sv
// Overview of operation
// R1 - target is (255 - code) times 62 mV
// R2 - controller never programs codes below 0x5D; the controller forwards them and flags a bad code on read back
// R3 - codes 0xB7 to 0xFF may not start
// R4 - controller reads setpoint back after writing
// R5 - controller avoids codes 0x5D through 0xA6; the controller forwards them and flags a bad code on read back
// R6 - measure supply only when enabled and good
// R7 - supply reading is 0.3606 V per lsb
// R8 - readout and flags valid only while enabled
// R9 - below low limit sets flag, fail silent
// R10 - low limit code is 0.3606 V per lsb
// R11 - above high limit sets flag, fail silent
// R12 - high limit code uses same scaling
// R13 - fail silent stops gate toggling
// R14 - temperature is code*215/106 minus 88 C
// R15 - codes below 0x18 mean under range
// R16 - fail silent stays after flag clear
// R17 - gate switches only while supply good
// R18 - writes to readout registers do nothing
package gsm_pkg;
   // ----------------------------------------
   // register map (link address space)
   // ----------------------------------------
   localparam logic [6:0] GSM_ADDR_DIAG     = 7'h0F;
   localparam logic [6:0] GSM_ADDR_SETPOINT = 7'h15;
   localparam logic [6:0] GSM_ADDR_HIGH_LIM = 7'h1A;
   localparam logic [6:0] GSM_ADDR_LOW_LIM  = 7'h1B;
   localparam logic [6:0] GSM_ADDR_VOLTAGE  = 7'h45;
   localparam logic [6:0] GSM_ADDR_TEMP     = 7'h46;
   // diagnostic register bit positions
   localparam int GSM_DIAG_GOOD_BIT = 5;
   localparam int GSM_DIAG_LOW_BIT  = 3;
   localparam int GSM_DIAG_HIGH_BIT = 2;
   // reset values
   localparam logic [7:0] GSM_SETPOINT_RST = 8'hB7;
   localparam logic [7:0] GSM_HIGH_LIM_RST = 8'hFF;
   localparam logic [7:0] GSM_LOW_LIM_RST  = 8'h00;
   // setpoint and temperature code bounds
   localparam logic [7:0] GSM_CODE_MAX_V    = 8'h5D;
   localparam logic [7:0] GSM_CODE_TOL_HI   = 8'hA6;
   localparam logic [7:0] GSM_CODE_MIN_V    = 8'hB7;
   localparam logic [7:0] GSM_TEMP_UNDER    = 8'h18;
   localparam int         GSM_STEP_MV       = 62;
   localparam int         GSM_FULL_CODE     = 255;
   // ----------------------------------------
   // controller register port
   // ----------------------------------------
   localparam logic [3:0] GSM_C_SETPOINT = 4'h0;
   localparam logic [3:0] GSM_C_HIGH_LIM = 4'h1;
   localparam logic [3:0] GSM_C_LOW_LIM  = 4'h2;
   localparam logic [3:0] GSM_C_STATUS   = 4'h3;
   localparam logic [3:0] GSM_C_VOLTAGE  = 4'h4;
   localparam logic [3:0] GSM_C_TEMP     = 4'h5;
   localparam logic [3:0] GSM_C_IRQ_STAT = 4'h6;
   localparam logic [3:0] GSM_C_IRQ_MASK = 4'h7;
   localparam logic [3:0] GSM_C_DIAG_CLR = 4'h8;
   // irq bit positions
   localparam int GSM_IRQ_LOW  = 0;
   localparam int GSM_IRQ_HIGH = 1;
   localparam int GSM_IRQ_BAD  = 2;
   localparam int GSM_IRQ_FAIL = 3;
   localparam logic [3:0] GSM_IRQ_MASK_RST = 4'h0;

   function automatic logic [15:0] gsm_target_mv(input logic [7:0] code);
      gsm_target_mv = 16'((GSM_FULL_CODE - int'(code)) * GSM_STEP_MV);
   endfunction
endpackage

// file: design/gsm_link_if.sv
`timescale 1ns/1ps
// register access link between controller and device
interface gsm_link_if;
   logic       wr;
   logic       rd;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       enable;
   logic       fail_silent;
   modport device (input wr, input rd, input addr, input wdata, input enable,
                   output rdata, output fail_silent);
   modport ctrl   (output wr, output rd, output addr, output wdata, output enable,
                   input rdata, input fail_silent);
endinterface

// file: design/gsm_device.sv
`timescale 1ns/1ps
module gsm_device
   import gsm_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   rst_b,
   gsm_link_if.device  link,
   input  wire logic [7:0] supply_sample,
   input  wire logic [7:0] temp_sample,
   input  wire logic   gate_supply_good,
   input  wire logic   gate_clk,
   output logic        gate_out,
   output logic [15:0] target_mv
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] gate_supply_code_r;
   logic [7:0] high_limit_code_r;
   logic [7:0] low_limit_code_r;
   logic [7:0] supply_r;
   logic [7:0] temp_r;
   logic       supply_low_flag_r;
   logic       supply_high_flag_r;
   logic       fail_silent_r;
   logic [7:0] rdata_r;

   wire measuring  = link.enable && gate_supply_good;                  // [R6] [R8]
   wire low_hit    = measuring && (supply_sample < low_limit_code_r);  // [R9] [R10]
   wire high_hit   = measuring && (supply_sample > high_limit_code_r); // [R11] [R12]
   wire diag_wr    = link.wr && (link.addr == GSM_ADDR_DIAG);
   wire [7:0] diag = {2'b00, gate_supply_good, 1'b0, supply_low_flag_r, supply_high_flag_r, 2'b00};

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (link.addr)
         GSM_ADDR_DIAG:     rd_mux = diag;
         GSM_ADDR_SETPOINT: rd_mux = gate_supply_code_r;
         GSM_ADDR_HIGH_LIM: rd_mux = high_limit_code_r;
         GSM_ADDR_LOW_LIM:  rd_mux = low_limit_code_r;
         GSM_ADDR_VOLTAGE:  rd_mux = link.enable ? supply_r : 8'h00; // [R8]
         GSM_ADDR_TEMP:     rd_mux = temp_r;                         // [R14] [R15]
         default:           rd_mux = 8'h00;
      endcase
   end

   // readout registers have no write path at all  [R18]
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gate_supply_code_r <= GSM_SETPOINT_RST;
         high_limit_code_r  <= GSM_HIGH_LIM_RST;
         low_limit_code_r   <= GSM_LOW_LIM_RST;
      end else if (link.wr) begin
         if (link.addr == GSM_ADDR_SETPOINT) gate_supply_code_r <= link.wdata; // [R1] [R3]
         if (link.addr == GSM_ADDR_HIGH_LIM) high_limit_code_r  <= link.wdata;
         if (link.addr == GSM_ADDR_LOW_LIM)  low_limit_code_r   <= link.wdata;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         supply_r <= 8'h00;
         temp_r   <= 8'h00;
         rdata_r  <= 8'h00;
      end else begin
         if (measuring) supply_r <= supply_sample; // [R6] [R7]
         temp_r  <= temp_sample;                   // [R14]
         rdata_r <= rd_mux;
      end
   end

   // set wins over clear; only reset leaves fail silent  [R16]
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         supply_low_flag_r  <= 1'b0;
         supply_high_flag_r <= 1'b0;
         fail_silent_r      <= 1'b0;
      end else begin
         supply_low_flag_r  <= low_hit  | (supply_low_flag_r  & ~diag_wr & link.enable);
         supply_high_flag_r <= high_hit | (supply_high_flag_r & ~diag_wr & link.enable);
         if (low_hit || high_hit) fail_silent_r <= 1'b1; // [R9] [R11] [R16]
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gate_out  <= 1'b0;
         target_mv <= 16'h0000;
      end else begin
         gate_out  <= gate_clk & gate_supply_good & link.enable & ~fail_silent_r; // [R13] [R17]
         target_mv <= gsm_target_mv(gate_supply_code_r);                          // [R1]
      end
   end

   assign link.rdata       = rdata_r;
   assign link.fail_silent = fail_silent_r;
endmodule

// file: design/gsm_ctrl.sv
`timescale 1ns/1ps
module gsm_ctrl
   import gsm_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   rst_b,
   gsm_link_if.ctrl    link,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic   wr,
   input  wire logic   rd,
   output logic [7:0]  rdata,
   output logic        irq
);
   // ----------------------------------------
   // shadow and status
   // ----------------------------------------
   logic [7:0] setpoint_r, high_r, low_r, volt_r, temp_r, diag_r;
   logic [3:0] irq_stat_r, irq_mask_r;
   logic       en_r, verify_r, bad_code_r;
   logic [6:0] l_addr_r;
   logic [7:0] l_wdata_r;
   logic       l_wr_r, l_rd_r;
   logic [2:0] poll_r;
   logic [6:0] pend_addr_r;
   logic       fail_q_r;

   wire code_bad = (link.rdata < GSM_CODE_MAX_V) || (link.rdata <= GSM_CODE_TOL_HI) ||
                   (link.rdata >= GSM_CODE_MIN_V);                          // [R2] [R3] [R5]
   wire [6:0] poll_addr = (poll_r == 3'd0) ? GSM_ADDR_VOLTAGE :
                          (poll_r == 3'd1) ? GSM_ADDR_TEMP : GSM_ADDR_DIAG;
   wire host_link = wr && (addr <= GSM_C_LOW_LIM || addr == GSM_C_DIAG_CLR);
   wire [3:0] events = {link.fail_silent & ~fail_q_r, bad_code_r,
                        en_r & diag_r[GSM_DIAG_HIGH_BIT], en_r & diag_r[GSM_DIAG_LOW_BIT]};
   wire stat_rd = rd && addr == GSM_C_IRQ_STAT;

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (addr)
         GSM_C_SETPOINT: rd_mux = setpoint_r;
         GSM_C_HIGH_LIM: rd_mux = high_r;
         GSM_C_LOW_LIM:  rd_mux = low_r;
         GSM_C_STATUS:   rd_mux = {6'h00, link.fail_silent, en_r} | (en_r ? {diag_r[5:2], 4'h0} : 8'h00); // [R8]
         GSM_C_VOLTAGE:  rd_mux = en_r ? volt_r : 8'h00; // [R8]
         GSM_C_TEMP:     rd_mux = temp_r;
         GSM_C_IRQ_STAT: rd_mux = {4'h0, irq_stat_r};
         GSM_C_IRQ_MASK: rd_mux = {4'h0, irq_mask_r};
         default:        rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         l_wr_r      <= 1'b0;
         l_rd_r      <= 1'b0;
         l_addr_r    <= 7'h00;
         l_wdata_r   <= 8'h00;
         verify_r    <= 1'b0;
         poll_r      <= 3'd0;
         pend_addr_r <= 7'h00;
      end else begin
         l_wr_r <= 1'b0;
         l_rd_r <= 1'b0;
         if (host_link) begin
            l_wr_r    <= 1'b1;
            l_wdata_r <= wdata;
            unique case (addr)
               GSM_C_SETPOINT: l_addr_r <= GSM_ADDR_SETPOINT;
               GSM_C_HIGH_LIM: l_addr_r <= GSM_ADDR_HIGH_LIM;
               GSM_C_LOW_LIM:  l_addr_r <= GSM_ADDR_LOW_LIM;
               default:        l_addr_r <= GSM_ADDR_DIAG;
            endcase
            verify_r <= (addr == GSM_C_SETPOINT); // [R4]
         end else if (verify_r) begin
            l_rd_r   <= 1'b1;
            l_addr_r <= GSM_ADDR_SETPOINT; // [R4]
            verify_r <= 1'b0;
         end else begin
            l_rd_r   <= 1'b1;
            l_addr_r <= poll_addr;
            poll_r <= (poll_r == 3'd2) ? 3'd0 : poll_r + 3'd1;
         end
         pend_addr_r <= l_rd_r ? l_addr_r : 7'h7F;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         setpoint_r <= GSM_SETPOINT_RST;
         high_r     <= GSM_HIGH_LIM_RST;
         low_r      <= GSM_LOW_LIM_RST;
         volt_r     <= 8'h00;
         temp_r     <= 8'h00;
         diag_r     <= 8'h00;
         bad_code_r <= 1'b0;
         en_r       <= 1'b0;
         irq_stat_r <= 4'h0;
         irq_mask_r <= GSM_IRQ_MASK_RST;
         rdata      <= 8'h00;
         irq        <= 1'b0;
         fail_q_r   <= 1'b0;
      end else begin
         bad_code_r <= 1'b0;
         fail_q_r   <= link.fail_silent;
         if (wr && addr == GSM_C_SETPOINT) setpoint_r <= wdata;
         if (wr && addr == GSM_C_HIGH_LIM) high_r <= wdata;
         if (wr && addr == GSM_C_LOW_LIM)  low_r <= wdata;
         if (wr && addr == GSM_C_STATUS)   en_r <= wdata[0];
         if (wr && addr == GSM_C_IRQ_MASK) irq_mask_r <= wdata[3:0];
         unique case (pend_addr_r)
            GSM_ADDR_VOLTAGE:  if (en_r) volt_r <= link.rdata; // [R8]
            GSM_ADDR_TEMP:     temp_r <= link.rdata;
            GSM_ADDR_DIAG:     diag_r <= link.rdata;
            GSM_ADDR_SETPOINT: bad_code_r <= code_bad;          // [R4]
            default:           ;
         endcase
         // set wins over the read clear
         irq_stat_r <= events | (stat_rd ? 4'h0 : irq_stat_r);
         irq        <= |((events | (stat_rd ? 4'h0 : irq_stat_r)) & irq_mask_r);
         rdata      <= rd_mux;
      end
   end

   assign link.wr     = l_wr_r;
   assign link.rd     = l_rd_r;
   assign link.addr   = l_addr_r;
   assign link.wdata  = l_wdata_r;
   assign link.enable = en_r;
endmodule

// file: sim/gsm_link_sva.sv
`timescale 1ns/1ps
module gsm_link_sva
   import gsm_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       enable,
   input wire logic       fail_silent
);
   // ----------------------------------------
   // link checks, one clock domain
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   property p_hold; fail_silent |=> fail_silent; endproperty
   a_hold: assert property (p_hold) else $error("fail silent dropped");
   property p_clr; wr && addr == GSM_ADDR_DIAG && fail_silent |=> fail_silent [*3]; endproperty
   a_clr: assert property (p_clr) else $error("diag clear left fail silent");
   property p_off; fail_silent && !enable |=> fail_silent; endproperty
   a_off: assert property (p_off) else $error("off mode left fail silent");
   // flag and fail register sit one stage behind the enable; the check allows up to three
   property p_cause; $rose(fail_silent) |-> $past(enable) || $past(enable, 2) || $past(enable, 3); endproperty
   a_cause: assert property (p_cause) else $error("fail silent without enable");
   property p_idle; !enable [*3] |=> !$rose(fail_silent); endproperty
   a_idle: assert property (p_idle) else $error("measured while disabled");
   property p_rb; wr && addr == GSM_ADDR_SETPOINT |=> rd && addr == GSM_ADDR_SETPOINT; endproperty
   a_rb: assert property (p_rb) else $error("no setpoint read back");
   property p_rbdata; wr && addr == GSM_ADDR_SETPOINT ##1 rd |=> rdata == $past(wdata, 2); endproperty
   a_rbdata: assert property (p_rbdata) else $error("setpoint read back differs");
   property p_ro; wr |-> addr != GSM_ADDR_VOLTAGE && addr != GSM_ADDR_TEMP; endproperty
   a_ro: assert property (p_ro) else $error("write to readout register");
   c_fail: cover property ($rose(fail_silent));
   c_diag: cover property (wr && addr == GSM_ADDR_DIAG);
   c_sp: cover property (rd && addr == GSM_ADDR_SETPOINT);
endmodule

// file: sim/gate_supply_and_supply_monitor_test.sv
`timescale 1ns/1ps
module gate_supply_and_supply_monitor_test;
   import gsm_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00, rdata, sup = 8'h00, tmp = 8'h00, v;
   logic        wr = 1'b0, rd = 1'b0, irq, good = 1'b0, gclk = 1'b0, gout, ib;
   logic [15:0] tmv;
   int          bad_count = 0, cmp_count = 0;
   int          codes[$] = '{'h5D, 'hA6, 'hA7, 'hB6, 'hB7, 'hFF};
   int          temps[$] = '{'h10, 'h18, 'h82};
   gsm_link_if link ();
   gsm_ctrl gsm_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
                           .rd(rd), .rdata(rdata), .irq(irq));
   gsm_device gsm_device_inst (.mclk(mclk), .rst_b(rst_b), .link(link), .supply_sample(sup), .temp_sample(tmp),
                               .gate_supply_good(good), .gate_clk(gclk), .gate_out(gout), .target_mv(tmv));
   gsm_link_sva gsm_link_sva_inst (.mclk(mclk), .rst_b(rst_b), .wr(link.wr), .rd(link.rd), .addr(link.addr),
                                   .wdata(link.wdata), .rdata(link.rdata), .enable(link.enable),
                                   .fail_silent(link.fail_silent));
   always #5 mclk = ~mclk;
   always @(posedge mclk) gclk <= ~gclk;
   // ----------------------------------------
   // bus tasks and compare
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // read data follow the address one cycle later, whether or not the strobe is high
   task automatic rreg(input logic [3:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask
   task automatic tog(input int exp);
      int   n;
      logic p;
      n = 0;
      #1;
      p = gout;
      repeat (16) begin
         @(posedge mclk);
         #1;
         n += int'(gout !== p);
         p = gout;
      end
      chk(16'(n), 16'(exp));
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(45));
      codes.push_back('hA7 + int'($urandom % 16));
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      rreg(GSM_C_SETPOINT);
      chk(v, 8'hB7);
      rreg(GSM_C_HIGH_LIM);
      chk(v, 8'hFF);
      rreg(GSM_C_LOW_LIM);
      chk(v, 8'h00);
      foreach (codes[i]) begin
         wreg(GSM_C_SETPOINT, codes[i][7:0]);
         repeat (4) @(posedge mclk);
         #1;
         chk(tmv, 16'((255 - codes[i]) * 62));
         rreg(GSM_C_SETPOINT);
         chk(v, codes[i][7:0]);
         rreg(GSM_C_IRQ_STAT);
         chk(v[2], codes[i] <= 'hA6 || codes[i] >= 'hB7);
      end
      // pending bad code: the mask must change the interrupt line
      wreg(GSM_C_SETPOINT, 8'h5D);
      repeat (4) @(posedge mclk);
      #1;
      ib = irq;
      wreg(GSM_C_IRQ_MASK, 8'h0F);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq ^ ib, 1);
      rreg(GSM_C_IRQ_STAT);
      wreg(GSM_C_IRQ_MASK, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq, 0);
      wreg(GSM_C_LOW_LIM, 8'h40);
      wreg(GSM_C_HIGH_LIM, 8'hC0);
      wreg(GSM_C_STATUS, 8'h01);
      good <= 1'b1;
      foreach (temps[i]) begin
         sup <= 8'h41 + 8'($urandom % 'h7E);
         tmp <= temps[i][7:0];
         repeat (8) @(posedge mclk);
         rreg(GSM_C_VOLTAGE);
         chk(v, sup);
         rreg(GSM_C_TEMP);
         chk(v, tmp);
      end
      tog(16);
      wreg(GSM_C_VOLTAGE, ~sup);
      rreg(GSM_C_VOLTAGE);
      chk(v, sup);
      rreg(4'hF);
      chk(v, 8'h00);
      sup <= 8'h3F;
      repeat (8) @(posedge mclk);
      rreg(GSM_C_STATUS);
      chk(v, 8'hA3);
      tog(0);
      rreg(GSM_C_IRQ_STAT);
      chk(v & 8'h09, 8'h09);
      sup <= 8'h80;
      wreg(GSM_C_DIAG_CLR, 8'h00);
      repeat (4) @(posedge mclk);
      rreg(GSM_C_STATUS);
      chk(v[1], 1);
      tog(0);
      wreg(GSM_C_STATUS, 8'h00);
      rreg(GSM_C_STATUS);
      chk(v[1:0], 2'b10);
      rreg(GSM_C_VOLTAGE);
      chk(v, 8'h00);
      // second reset, then overvoltage with and without a good gate supply
      rst_b <= 1'b0;
      good <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      wreg(GSM_C_HIGH_LIM, 8'h80);
      wreg(GSM_C_STATUS, 8'h01);
      sup <= 8'h81;
      tog(0);
      rreg(GSM_C_STATUS);
      chk(v[1], 0);
      good <= 1'b1;
      repeat (8) @(posedge mclk);
      rreg(GSM_C_IRQ_STAT);
      chk(v & 8'h0A, 8'h0A);
      complete_run();
   end
endmodule
